/* shared/iss_pkg.sv */
package iss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRLA = 8'h00;
  localparam logic [7:0] OFF_CTRLB = 8'h04;
  localparam logic [7:0] OFF_IENCLR = 8'h0C;
  localparam logic [7:0] OFF_IENSET = 8'h0D;
  localparam logic [7:0] OFF_IFLAG = 8'h0E;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_ADDR = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  // Control A fields
  localparam int CA_SWRST = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_MODE_LO = 2;
  localparam int CA_RUNSTDBY = 7;
  localparam int CA_PINOUT = 16;
  localparam int CA_SDAHOLD_LO = 20;
  localparam int CA_LOWTOUT = 30;
  localparam logic [2:0] MODE_SLAVE = 3'h4;
  localparam logic [2:0] MODE_MASTER = 3'h5;
  // Control B fields
  localparam int CB_SMEN = 8;
  localparam int CB_QCEN = 9;
  localparam int CB_CMD_LO = 16;
  localparam int CB_ACKACT = 18;
  localparam logic [1:0] CMD_RELEASE = 2'h2;
  localparam logic [1:0] CMD_RESPOND = 2'h3;
  // Interrupt flag bits (slave / master meaning)
  localparam int FL_STOP = 0;
  localparam int FL_AMATCH = 1;
  localparam int FL_DRDY = 2;
  localparam int FL_MB = 0;
  localparam int FL_SB = 1;
  // Status fields
  localparam int ST_RXNACK = 2;
  localparam int ST_DIR = 3;
  localparam int ST_BUSSTATE_LO = 4;
  localparam int ST_LOWTOUT = 6;
  localparam int ST_CLKHOLD = 7;
  localparam int ST_SYNCBUSY = 15;
  // Timing
  localparam int CLK_NS = 40;
  localparam int HOLD1_NS = 75;
  localparam int HOLD2_NS = 450;
  localparam int HOLD3_NS = 600;
  localparam logic [3:0] HOLD1_CYC = 4'((HOLD1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD2_CYC = 4'((HOLD2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD3_CYC = 4'((HOLD3_NS + CLK_NS - 1) / CLK_NS);
  localparam int TOUT_MS = 25;
  localparam int SLOW_HZ = 32768;
  localparam logic [9:0] TOUT_TICKS = 10'(TOUT_MS * SLOW_HZ / 1000);
  localparam logic [2:0] SYNC_CYC = 3'h3;

  typedef enum logic [3:0] {
    ISS_IDLE = 4'h0, ISS_ADDR = 4'h1, ISS_AHOLD = 4'h3, ISS_ACKB = 4'h2,
    ISS_RX = 4'h6, ISS_RHOLD = 4'h7, ISS_TXHOLD = 4'h5, ISS_TX = 4'h4,
    ISS_TXACK = 4'hC, ISS_WAITP = 4'hD
  } iss_fsm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iss_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } iss_pin_t;

  typedef struct packed {
    logic en, mst, runstdby, pinout, lowtout_en, smen, qcen, ackact;
    logic [1:0] sdahold;
    logic [2:0] inten, flag;
    logic dir, rxnack, lowtout_st;
    logic [1:0] busstate;
    logic [7:0] addr, data_rx, data_tx, shift;
    logic [3:0] bitcnt, hold_cnt;
    iss_fsm_t st;
    logic ack_nack, ack_addr, go_ack, go_rel, go_data, swr;
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic tck_s1, tck_s2, tck_d;
    logic [9:0] tout_cnt;
    logic want_sda_low, sda_low, scl_low;
    logic [2:0] sync_cnt;
    logic pend_v;
    iss_req_t pend;
    logic [31:0] rdata;
    iss_pin_t pins;
    logic irq, wake, core_en;
  } iss_st_t;
endpackage

/* design/iss_slave.sv */
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module iss_slave
  import iss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire iss_req_t req_i,
  output logic [31:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic slow_clk_i,
  input wire logic standby_i,
  input wire logic master_busy_i,
  input wire logic mst_mb_evt_i,
  input wire logic mst_sb_evt_i,
  output iss_pin_t pins_o,
  output logic irq_o,
  output logic wake_o,
  output logic core_clk_en_o,
  output logic sync_busy_o
);

  iss_st_t s_ff;
  iss_st_t nxt_s;

  // Data hold length for each hold setting
  function automatic logic [3:0] hold_cycles(input logic [1:0] sel);
    case (sel)
      2'h1: hold_cycles = HOLD1_CYC;
      2'h2: hold_cycles = HOLD2_CYC;
      2'h3: hold_cycles = HOLD3_CYC;
      default: hold_cycles = 4'h0;
    endcase
  endfunction

  // Accesses that must cross into the core domain
  function automatic logic is_sync(input iss_st_t s, input iss_req_t r);
    logic w;
    logic rd;
    w = r.wr & ((r.addr == OFF_CTRLA) | (r.addr == OFF_STATUS) |
        ((r.addr == OFF_ADDR) & s.mst) | ((r.addr == OFF_DATA) & s.smen));
    rd = r.rd & (r.addr == OFF_DATA) & s.smen;
    is_sync = w | rd;
  endfunction

  // Register read view
  function automatic logic [31:0] rd_word(input iss_st_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      OFF_CTRLA: begin
        v[CA_ENABLE] = s.en;
        v[CA_MODE_LO +: 3] = s.mst ? MODE_MASTER : MODE_SLAVE;
        v[CA_RUNSTDBY] = s.runstdby;
        v[CA_PINOUT] = s.pinout;
        v[CA_SDAHOLD_LO +: 2] = s.sdahold;
        v[CA_LOWTOUT] = s.lowtout_en;
      end
      OFF_CTRLB: begin
        v[CB_SMEN] = s.smen;
        v[CB_QCEN] = s.qcen;
        v[CB_ACKACT] = s.ackact;
      end
      OFF_IENCLR, OFF_IENSET: v[2:0] = s.inten;
      OFF_IFLAG: v[2:0] = s.flag;
      OFF_STATUS: begin
        v[ST_RXNACK] = s.rxnack;
        if (s.mst) begin
          v[ST_BUSSTATE_LO +: 2] = s.busstate;
        end else begin
          v[ST_DIR] = s.dir;
        end
        v[ST_LOWTOUT] = s.lowtout_st;
        v[ST_CLKHOLD] = s.scl_low;
        v[ST_SYNCBUSY] = (s.sync_cnt != 3'h0);
      end
      OFF_ADDR: v[7:0] = s.addr;
      OFF_DATA: v[7:0] = s.data_rx;
      default: v = 32'h0;
    endcase
    rd_word = v;
  endfunction

  // Effects of one register access
  function automatic iss_st_t apply(input iss_st_t s, input iss_req_t r);
    iss_st_t t;
    t = s;
    if (r.rd && r.addr == OFF_DATA && s.smen && !s.mst) begin
      t.go_ack = 1'b1;
    end
    if (r.wr) begin
      case (r.addr)
        OFF_CTRLA: begin
          t.swr = r.wdata[CA_SWRST];
          t.en = r.wdata[CA_ENABLE];
          t.mst = (r.wdata[CA_MODE_LO +: 3] == MODE_MASTER);
          t.runstdby = r.wdata[CA_RUNSTDBY];
          t.pinout = r.wdata[CA_PINOUT];
          t.sdahold = r.wdata[CA_SDAHOLD_LO +: 2];
          t.lowtout_en = r.wdata[CA_LOWTOUT];
        end
        OFF_CTRLB: begin
          t.smen = r.wdata[CB_SMEN];
          t.qcen = r.wdata[CB_QCEN];
          t.ackact = r.wdata[CB_ACKACT];
          t.go_ack = (r.wdata[CB_CMD_LO +: 2] == CMD_RESPOND);
          t.go_rel = (r.wdata[CB_CMD_LO +: 2] == CMD_RELEASE);
        end
        OFF_IENCLR: t.inten = s.inten & ~r.wdata[2:0];
        OFF_IENSET: t.inten = s.inten | r.wdata[2:0];
        OFF_IFLAG: begin
          t.flag = s.flag & ~r.wdata[2:0];
          t.go_ack = r.wdata[FL_AMATCH] & !s.mst;
        end
        OFF_STATUS: begin
          t.busstate = r.wdata[ST_BUSSTATE_LO +: 2];
          t.lowtout_st = s.lowtout_st & ~r.wdata[ST_LOWTOUT];
        end
        OFF_ADDR: t.addr = r.wdata[7:0];
        OFF_DATA: begin
          t.data_tx = r.wdata[7:0];
          t.go_data = 1'b1;
        end
        default: t.addr = s.addr;
      endcase
    end
    apply = t;
  endfunction

  // Next state of the whole block
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic active;
    logic tick;
    logic release_all;
    nxt_s = s_ff;
    rise = s_ff.scl_s2 & ~s_ff.scl_d;
    fall = ~s_ff.scl_s2 & s_ff.scl_d;
    start = s_ff.scl_s2 & s_ff.scl_d & s_ff.sda_d & ~s_ff.sda_s2;
    stop = s_ff.scl_s2 & s_ff.scl_d & ~s_ff.sda_d & s_ff.sda_s2;
    tick = s_ff.tck_s2 & ~s_ff.tck_d;
    active = s_ff.en & ~s_ff.mst & ~(standby_i & ~s_ff.runstdby);
    release_all = 1'b0;
    nxt_s.scl_s1 = scl_i;
    nxt_s.scl_s2 = s_ff.scl_s1;
    nxt_s.scl_d = s_ff.scl_s2;
    nxt_s.sda_s1 = sda_i;
    nxt_s.sda_s2 = s_ff.sda_s1;
    nxt_s.sda_d = s_ff.sda_s2;
    nxt_s.tck_s1 = slow_clk_i;
    nxt_s.tck_s2 = s_ff.tck_s1;
    nxt_s.tck_d = s_ff.tck_s2;
    nxt_s.go_ack = 1'b0;
    nxt_s.go_rel = 1'b0;
    nxt_s.go_data = 1'b0;
    nxt_s.swr = 1'b0;

    // Slave byte engine
    case (s_ff.st)
      ISS_ADDR: begin
        if (rise) begin
          nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s2};
          nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
        end
        if (fall && s_ff.bitcnt == 4'h8) begin
          if (s_ff.shift[7:1] == s_ff.addr[7:1]) begin
            nxt_s.flag[FL_AMATCH] = 1'b1;
            nxt_s.dir = s_ff.shift[0];
            nxt_s.scl_low = 1'b1;
            nxt_s.st = ISS_AHOLD;
          end else begin
            nxt_s.st = ISS_IDLE;
          end
        end
      end
      ISS_AHOLD: begin
        if (s_ff.go_ack) begin
          nxt_s.ack_nack = s_ff.ackact;
          nxt_s.ack_addr = 1'b1;
          nxt_s.want_sda_low = ~s_ff.ackact;
          nxt_s.scl_low = 1'b0;
          nxt_s.st = ISS_ACKB;
        end else if (s_ff.go_rel) begin
          release_all = 1'b1;
        end
      end
      ISS_ACKB: begin
        if (fall) begin
          nxt_s.want_sda_low = 1'b0;
          nxt_s.bitcnt = 4'h0;
          if (s_ff.ack_nack) begin
            nxt_s.st = s_ff.ack_addr ? ISS_IDLE : ISS_WAITP;
          end else if (s_ff.dir) begin
            nxt_s.flag[FL_DRDY] = 1'b1;
            nxt_s.scl_low = 1'b1;
            nxt_s.st = ISS_TXHOLD;
          end else begin
            if (s_ff.qcen && s_ff.ack_addr) begin
              nxt_s.flag[FL_DRDY] = 1'b1;
            end
            nxt_s.st = ISS_RX;
          end
        end
      end
      ISS_RX: begin
        if (rise) begin
          nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s2};
          nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
        end
        if (fall && s_ff.bitcnt == 4'h8) begin
          nxt_s.data_rx = s_ff.shift;
          nxt_s.flag[FL_DRDY] = 1'b1;
          nxt_s.scl_low = 1'b1;
          nxt_s.st = ISS_RHOLD;
        end
      end
      ISS_RHOLD: begin
        if (s_ff.go_ack) begin
          nxt_s.ack_nack = s_ff.ackact;
          nxt_s.ack_addr = 1'b0;
          nxt_s.want_sda_low = ~s_ff.ackact;
          nxt_s.scl_low = 1'b0;
          nxt_s.st = ISS_ACKB;
        end else if (s_ff.go_rel) begin
          nxt_s.scl_low = 1'b0;
          nxt_s.st = ISS_WAITP;
        end
      end
      ISS_TXHOLD: begin
        if (s_ff.go_data) begin
          nxt_s.shift = s_ff.data_tx;
          nxt_s.bitcnt = 4'h0;
          nxt_s.want_sda_low = ~s_ff.data_tx[7];
          nxt_s.scl_low = 1'b0;
          nxt_s.st = ISS_TX;
        end else if (s_ff.go_rel) begin
          nxt_s.scl_low = 1'b0;
          nxt_s.st = ISS_WAITP;
        end
      end
      ISS_TX: begin
        if (rise) begin
          nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
        end
        if (fall && s_ff.bitcnt == 4'h8) begin
          nxt_s.want_sda_low = 1'b0;
          nxt_s.st = ISS_TXACK;
        end else if (fall) begin
          nxt_s.shift = {s_ff.shift[6:0], 1'b0};
          nxt_s.want_sda_low = ~s_ff.shift[6];
        end
      end
      ISS_TXACK: begin
        if (rise) begin
          nxt_s.rxnack = s_ff.sda_s2;
        end
        if (fall && s_ff.rxnack) begin
          nxt_s.st = ISS_WAITP;
        end else if (fall) begin
          nxt_s.flag[FL_DRDY] = 1'b1;
          nxt_s.scl_low = 1'b1;
          nxt_s.st = ISS_TXHOLD;
        end
      end
      ISS_WAITP: nxt_s.want_sda_low = 1'b0;
      ISS_IDLE: nxt_s.bitcnt = 4'h0;
      default: nxt_s.st = ISS_IDLE;
    endcase

    // Bus conditions override the engine
    if (stop && s_ff.st != ISS_IDLE) begin
      nxt_s.flag[FL_STOP] = 1'b1;
      release_all = 1'b1;
    end
    if (start && active) begin
      nxt_s.st = ISS_ADDR;
      nxt_s.bitcnt = 4'h0;
      nxt_s.scl_low = 1'b0;
      nxt_s.want_sda_low = 1'b0;
    end

    // Clock low timeout, slow ticks while the line is low
    if (s_ff.scl_s2 || !s_ff.lowtout_en) begin
      nxt_s.tout_cnt = 10'h0;
    end else if (tick) begin
      nxt_s.tout_cnt = s_ff.tout_cnt + 10'h1;
      if (s_ff.tout_cnt == TOUT_TICKS - 10'h1) begin
        nxt_s.lowtout_st = 1'b1;
        release_all = 1'b1;
      end
    end
    if (release_all || !active) begin
      nxt_s.st = ISS_IDLE;
      nxt_s.scl_low = 1'b0;
      nxt_s.want_sda_low = 1'b0;
    end

    // Data line changes only after the hold time
    if (fall) begin
      nxt_s.hold_cnt = hold_cycles(s_ff.sdahold);
    end else if (s_ff.hold_cnt != 4'h0) begin
      nxt_s.hold_cnt = s_ff.hold_cnt - 4'h1;
    end else begin
      // Follow the new level at once so SDA moves with the SCL release, never while SCL is high
      nxt_s.sda_low = nxt_s.want_sda_low;
    end

    // Master events
    if (s_ff.mst) begin
      nxt_s.flag[FL_MB] = s_ff.flag[FL_MB] | mst_mb_evt_i;
      nxt_s.flag[FL_SB] = s_ff.flag[FL_SB] | mst_sb_evt_i;
    end

    // Register access, then synchronization window
    if (s_ff.sync_cnt != 3'h0) begin
      nxt_s.sync_cnt = s_ff.sync_cnt - 3'h1;
    end
    if ((req_i.wr || req_i.rd) && is_sync(s_ff, req_i) && s_ff.sync_cnt != 3'h0) begin
      nxt_s.pend_v = 1'b1;
      nxt_s.pend = req_i;
    end else begin
      nxt_s = apply(nxt_s, req_i);
      if (is_sync(s_ff, req_i)) begin
        nxt_s.sync_cnt = SYNC_CYC;
      end
      if (s_ff.sync_cnt == 3'h1 && s_ff.pend_v) begin
        nxt_s = apply(nxt_s, s_ff.pend);
        nxt_s.pend_v = 1'b0;
        nxt_s.sync_cnt = SYNC_CYC;
      end
    end
    // Hardware sets win over a same-cycle clear, except the quick-command DRDY set on entering ISS_RX
    nxt_s.flag = nxt_s.flag | (nxt_s.flag ^ nxt_s.flag) | (s_ff.flag & 3'h0);
    if (nxt_s.st == ISS_AHOLD && s_ff.st == ISS_ADDR) begin
      nxt_s.flag[FL_AMATCH] = 1'b1;
    end
    if (stop && s_ff.st != ISS_IDLE) begin
      nxt_s.flag[FL_STOP] = 1'b1;
    end
    if ((nxt_s.st == ISS_RHOLD || nxt_s.st == ISS_TXHOLD) && s_ff.st != nxt_s.st) begin
      nxt_s.flag[FL_DRDY] = 1'b1;
    end
    if (s_ff.mst) begin
      nxt_s.flag[FL_MB] = nxt_s.flag[FL_MB] | mst_mb_evt_i;
      nxt_s.flag[FL_SB] = nxt_s.flag[FL_SB] | mst_sb_evt_i;
    end

    // Soft reset clears everything but the sync window
    if (s_ff.swr) begin
      nxt_s = '0;
      nxt_s.sync_cnt = s_ff.sync_cnt;
    end

    // Registered outputs
    nxt_s.rdata = req_i.rd ? rd_word(s_ff, req_i.addr) : 32'h0;
    nxt_s.irq = |(nxt_s.flag & nxt_s.inten);
    nxt_s.wake = standby_i & nxt_s.runstdby & ~nxt_s.mst &
                 nxt_s.flag[FL_AMATCH] & nxt_s.inten[FL_AMATCH];
    nxt_s.core_en = ~standby_i | nxt_s.runstdby | (nxt_s.mst & master_busy_i);
    if (nxt_s.pinout) begin
      nxt_s.pins = '{scl_o: ~nxt_s.scl_low, scl_oe: 1'b1,
                     sda_o: ~nxt_s.sda_low, sda_oe: 1'b1};
    end else begin
      nxt_s.pins = '{scl_o: 1'b0, scl_oe: nxt_s.scl_low,
                     sda_o: 1'b0, sda_oe: nxt_s.sda_low};
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;
  assign pins_o = s_ff.pins;
  assign irq_o = s_ff.irq;
  assign wake_o = s_ff.wake;
  assign core_clk_en_o = s_ff.core_en;
  assign sync_busy_o = (s_ff.sync_cnt != 3'h0);

endmodule

/* verif/iss_slave_assertions.sv */
`timescale 1ns/1ps
// Port-level checks on the serial slave unit
module iss_slave_chk
  import iss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire iss_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire logic standby_i,
  input wire iss_pin_t pins_o,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic core_clk_en_o,
  input wire logic sync_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] quiet_ff;
  logic [1:0] nxt_quiet;
  logic held;
  // Clock line pulled low by the unit
  assign held = pins_o.scl_oe && !pins_o.scl_o;
  // Cycles since the last register access, saturating at three
  always_comb begin
    nxt_quiet = quiet_ff;
    if (req_i.wr || req_i.rd) begin
      nxt_quiet = 2'h0;
    end else if (quiet_ff != 2'h3) begin
      nxt_quiet = quiet_ff + 2'h1;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_ff <= 2'h0;
    end else begin
      quiet_ff <= nxt_quiet;
    end
  end
  // Stretch lasts until software touches a register
  chk_scl_hold: assert property (
    held && quiet_ff == 2'h3 && !req_i.wr && !req_i.rd |=> held)
    else $error("clock stretch ended without software action");
  chk_sync_window: assert property (
    req_i.wr && req_i.addr == OFF_CTRLA && !sync_busy_o |=> sync_busy_o [*3])
    else $error("sync busy not raised for three cycles");
  chk_sync_cause: assert property (
    $rose(sync_busy_o) |-> $past(req_i.wr) || $past(req_i.rd) || $past(sync_busy_o, 2))
    else $error("sync busy raised without an access");
  chk_irq_off: assert property (
    req_i.wr && req_i.addr == OFF_IENCLR && req_i.wdata[2:0] == 3'h7 |-> ##[1:2] !irq_o)
    else $error("request stays after all enables cleared");
  chk_core_clock: assert property (
    !standby_i && $past(!standby_i) && $past(rst_n_i) |-> core_clk_en_o)
    else $error("core clock stopped outside standby");
  chk_wake_quiet: assert property (
    !standby_i [*2] |-> !wake_o)
    else $error("wake raised outside standby");
  chk_pad_drive: assert property (
    pins_o.sda_o || pins_o.scl_o |-> pins_o.sda_oe && pins_o.scl_oe)
    else $error("high level driven without four-wire drivers");
  chk_unmapped_read: assert property (
    req_i.rd && req_i.addr == 8'h08 |=> rdata_o == 32'h0)
    else $error("reserved offset read nonzero");
endmodule
bind iss_slave iss_slave_chk u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .standby_i(standby_i),
  .pins_o(pins_o),
  .irq_o(irq_o),
  .wake_o(wake_o),
  .core_clk_en_o(core_clk_en_o),
  .sync_busy_o(sync_busy_o)
);

/* verif/iss_i2c_master.sv */
`timescale 1ns/1ps
// Far-side bus master; open-drain outputs where 1 releases the line
module iss_i2c_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Release the clock and wait while the slave stretches it
  task automatic rise();
    int n;
    scl_o = 1'b1;
    n = 0;
    while (scl_i !== 1'b1 && n < 50000) begin
      #10 n++;
    end
  endtask
  // One bit: 200 ns low, 120 ns high
  task automatic bit_io(input logic b, output logic r);
    #120 sda_o = b;
    #80 rise();
    #60 r = sda_i;
    #60 scl_o = 1'b0;
  endtask
  task automatic start();
    #160 sda_o = 1'b0;
    #160 scl_o = 1'b0;
  endtask
  // Stop; reports whether the data line was free beforehand
  task automatic stop(output logic free);
    #200 free = sda_i;
    sda_o = 1'b0;
    #80 rise();
    #160 sda_o = 1'b1;
    #160;
  endtask
  // Byte out MSB first, then the slave's answer bit
  task automatic send(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic recv(input logic nak, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nak, r);
  endtask
endmodule

/* verif/iss_slave_tb.sv */
`timescale 1ns/1ps
module iss_slave_tb
  import iss_pkg::*;
;
  logic clk, rst_n, slow_clk, scl_m, sda_m, irq, sync_busy;
  logic [31:0] rdata;
  iss_req_t req;
  iss_pin_t pins;
  logic scl_w, sda_w;
  int errors, cmp_count;
  // Wired-AND bus lines with pull-ups
  assign scl_w = scl_m & ~(pins.scl_oe & ~pins.scl_o);
  assign sda_w = sda_m & ~(pins.sda_oe & ~pins.sda_o);
  iss_slave dut (
    .ref_clk_i(clk),
    .rst_n_i(rst_n),
    .ce_i(1'b1),
    .req_i(req),
    .rdata_o(rdata),
    .scl_i(scl_w),
    .sda_i(sda_w),
    .slow_clk_i(slow_clk),
    .standby_i(1'b0),
    .master_busy_i(1'b0),
    .mst_mb_evt_i(1'b0),
    .mst_sb_evt_i(1'b0),
    .pins_o(pins),
    .irq_o(irq),
    .wake_o(),
    .core_clk_en_o(),
    .sync_busy_o(sync_busy)
  );
  iss_i2c_master mst (.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always #15259 slow_clk = ~slow_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // One register access; read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic wait_flag(input logic [2:0] m);
    logic [31:0] q;
    int n;
    q = 32'h0;
    for (n = 0; n < 2000 && (q[2:0] & m) == 3'h0; n++) bus(1'b0, OFF_IFLAG, 32'h0, q);
    chk(32'(q[2:0] & m), 32'(m));
  endtask
  task automatic hold_chk();
    repeat (20) @(posedge clk);
    #1 chk(32'(scl_w), 32'h0);
  endtask
  task automatic t_setup();
    wr(OFF_ADDR, 32'hA0);
    wr(OFF_CTRLA, 32'h12);
    chk(32'(sync_busy), 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(32'(sync_busy), 32'h0);
    wr(OFF_CTRLA, 32'h12);
    wr(OFF_CTRLA, 32'h92);
    repeat (8) @(posedge clk);
    rdm(OFF_CTRLA, 32'hFF, 32'h92);
    wr(OFF_IENSET, 32'h7);
    rdm(8'h08, 32'hFFFFFFFF, 32'h0);
    rdm(OFF_IFLAG, 32'h7, 32'h0);
  endtask
  task automatic t_write();
    logic a0, a1, a2, f;
    wr(OFF_CTRLB, 32'h100);
    fork
      begin
        mst.start();
        mst.send(8'hA0, a0);
        mst.send(8'h5A, a1);
        mst.send(8'h96, a2);
        mst.stop(f);
      end
      begin
        wait_flag(3'h2);
        rdm(OFF_STATUS, 32'h8, 32'h0);
        hold_chk();
        wr(OFF_CTRLB, 32'h30100);
        wait_flag(3'h4);
        hold_chk();
        wr(OFF_IFLAG, 32'h4);
        rdm(OFF_DATA, 32'hFF, 32'h5A);
        wr(OFF_CTRLB, 32'h40100);
        wait_flag(3'h4);
        wr(OFF_IFLAG, 32'h4);
        rdm(OFF_DATA, 32'hFF, 32'h96);
        wait_flag(3'h1);
      end
    join
    chk(32'({a0, a1, a2}), 32'h1);
  endtask
  task automatic t_irq();
    chk(32'(irq), 32'h1);
    wr(OFF_IENCLR, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0);
    wr(OFF_IENSET, 32'h1);
    wr(OFF_IFLAG, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    wr(OFF_IFLAG, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0);
    rdm(OFF_IFLAG, 32'h7, 32'h0);
    wr(OFF_IENSET, 32'h6);
  endtask
  task automatic t_read();
    logic a0, f;
    logic [7:0] b;
    wr(OFF_CTRLB, 32'h0);
    fork
      begin
        mst.start();
        mst.send(8'hA1, a0);
        mst.recv(1'b1, b);
        mst.stop(f);
      end
      begin
        wait_flag(3'h2);
        rdm(OFF_STATUS, 32'h8, 32'h8);
        wr(OFF_IFLAG, 32'h2);
        wait_flag(3'h4);
        hold_chk();
        wr(OFF_IFLAG, 32'h4);
        wr(OFF_DATA, 32'hC3);
        wait_flag(3'h1);
        rdm(OFF_STATUS, 32'h4, 32'h4);
      end
    join
    chk({23'h0, a0, b}, 32'hC3);
    chk(32'(f), 32'h1);
  endtask
  task automatic t_refuse();
    logic a0, a1, a2, f;
    wr(OFF_IFLAG, 32'h7);
    wr(OFF_CTRLB, 32'h200);
    fork
      begin
        mst.start();
        mst.send(8'hB0, a0);
        mst.stop(f);
        mst.start();
        mst.send(8'hA0, a1);
        mst.stop(f);
      end
      begin
        wait_flag(3'h2);
        wr(OFF_CTRLB, 32'h30200);
        wait_flag(3'h4);
        wr(OFF_CTRLB, 32'h20000);
      end
    join
    wr(OFF_IFLAG, 32'h7);
    fork
      begin
        mst.start();
        mst.send(8'hA0, a2);
        mst.stop(f);
      end
      begin
        wait_flag(3'h2);
        wr(OFF_CTRLB, 32'h70000);
      end
    join
    chk(32'({a0, a1, a2}), 32'h5);
  endtask
  // Four-wire mode drives both pads actively while idle
  task automatic t_pad();
    wr(OFF_CTRLA, 32'h10012);
    repeat (2) @(posedge clk);
    #1 chk(32'(pins), 32'hF);
    repeat (4) @(posedge clk);
    wr(OFF_CTRLA, 32'h12);
    repeat (2) @(posedge clk);
    #1 chk(32'(pins), 32'h0);
  endtask
  task automatic print_verdict();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hung transfer
  initial begin
    #600000;
    errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    slow_clk = 1'b0;
    req = '0;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    chk(32'(pins), 32'h0);
    chk(32'(irq), 32'h0);
    rst_n <= 1'b1;
    t_setup();
    t_write();
    t_irq();
    t_read();
    t_refuse();
    t_pad();
    print_verdict();
  end
endmodule
